// >>> rtl/nhba_addr_pack.v
`timescale 1ns/1ps
`include "nhba_map.vh"
// ----------------------------------------------------------------
// Address byte packer.
// ----------------------------------------------------------------
module nhba_addr_pack
(
    columnAddr,
    pageAddr,
    blockAddr,
    byteIdx,
    addrByte,
    addrBad
);
    input wire [12:0] columnAddr;
    input wire [5:0] pageAddr;
    input wire [16:0] blockAddr;
    input wire [2:0] byteIdx;
    output reg [7:0] addrByte;
    output wire addrBad;

    assign addrBad = columnAddr[`NHBA_CA12_BIT] &
        (|columnAddr[11:8]);

    always @*
    begin
        case (byteIdx)
            3'h0: addrByte = columnAddr[7:0];
            3'h1: addrByte = {3'h0, columnAddr[12:8]};
            3'h2: addrByte = {blockAddr[1:0], pageAddr};
            3'h3: addrByte = blockAddr[9:2];
            3'h4: addrByte = {7'h00, blockAddr[10]};
            default: addrByte = 8'h00;
        endcase
    end
endmodule

// >>> rtl/nhba_host.v
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "nhba_map.vh"
// Functional notes
// - Reset command is sent first after power-up before anything else; the host blocks only other commands, not address or data cycles.
// - Commands, addresses and data share one 8-bit two-way bus.
// - Lock strap high at power-up enables block lock; low disables.
// - Page is 4096 plus 256 bytes; block holds 64 pages.
// - Five address bytes: column low, column high, page+block, block, block.
// - When column bit 12 is set, column bits 11..8 are zero.
// - Command latched on write strobe rise, CE low, CLE high, ALE low.
// - Address latched on write strobe rise, CE low, ALE high, CLE low.
module nhba_host
#(
    parameter ADDR_W = 5
)
(
    clock,
    sys_rst,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    ioIn,
    ioOut,
    ioOe,
    chipSel0_n,
    chipSel1_n,
    cmdLatch,
    addrLatch,
    writeStrobe_n,
    read_strobe_n,
    writeGuard_n,
    lockStrap,
    readyBusy0_n,
    readyBusy1_n,
    irq
);
    input wire clock;
    input wire sys_rst;
    input wire [ADDR_W-1:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output wire s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output wire s_axi_wready;
    output wire [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [ADDR_W-1:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output wire s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    input wire [7:0] ioIn;
    output reg [7:0] ioOut;
    output reg ioOe;
    output reg chipSel0_n;
    output reg chipSel1_n;
    output reg cmdLatch;
    output reg addrLatch;
    output reg writeStrobe_n;
    output reg read_strobe_n;
    output reg writeGuard_n;
    output reg lockStrap;
    input wire readyBusy0_n;
    input wire readyBusy1_n;
    output wire irq;

    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_PULSE = 3'h2;
    localparam S_HOLD = 3'h3;
    localparam S_DONE = 3'h4;

    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [1:0] kind_r;
    reg [2:0] addrIdx_r;
    reg [7:0] byte_r;
    reg [7:0] rdByte_r;
    reg target_r;
    reg initDone_r;
    reg errEv_r;
    reg doneEv_r;
    reg [12:0] columnAddr;
    reg [5:0] page_addr_r;
    reg [16:0] blockAddr_r;
    reg [7:0] cmdByte_r;
    reg awHeld_r;
    reg wHeld_r;
    reg [ADDR_W-1:0] awAddr_r;
    reg [31:0] wData_r;
    reg rdyPrev_r;
    wire [7:0] packByte;
    wire addrBad;
    wire [2:0] irqStat;
    wire [2:0] irqMask;
    wire wrFire;
    wire [3:0] wIdx;
    wire [3:0] rIdx;
    wire selReady;
    wire goReq;
    wire cmdOk;

    // ------------------------------------------------------------
    // Register bus.
    // ------------------------------------------------------------
    assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign s_axi_bresp = 2'h0;
    assign wrFire = awHeld_r & wHeld_r;
    assign wIdx = {1'b0, awAddr_r[ADDR_W-1:2]};
    assign rIdx = {1'b0, s_axi_araddr[ADDR_W-1:2]};
    assign selReady = target_r ? readyBusy1_n : readyBusy0_n;
    assign goReq = wrFire && wIdx == `NHBA_REG_CTRL &&
        wData_r[`NHBA_CTRL_GO] && state_r == S_IDLE;
    // Commands: before the reset command only reset goes; while busy only reset and status go.
    assign cmdOk = (kind_r != `NHBA_KIND_CMD) ||
        (cmdByte_r == `NHBA_CMD_RESET) ||
        (initDone_r && ((wData_r[`NHBA_CTRL_CE] ? readyBusy1_n :
        readyBusy0_n) ||
        cmdByte_r == `NHBA_CMD_STATUS ||
        cmdByte_r == `NHBA_CMD_STATUS_ENH));

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= {ADDR_W{1'b0}};
            wData_r <= 32'h00000000;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
            end
            if (wrFire)
            begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (rIdx)
                    `NHBA_REG_CTRL: s_axi_rdata <= {28'h0, lockStrap,
                        target_r, ~writeGuard_n, 1'b0};
                    `NHBA_REG_ADDRLO: s_axi_rdata <= {13'h0,
                        page_addr_r, columnAddr};
                    `NHBA_REG_ADDRHI: s_axi_rdata <= {15'h0,
                        blockAddr_r};
                    `NHBA_REG_DATA: s_axi_rdata <= {22'h0, kind_r,
                        cmdByte_r};
                    `NHBA_REG_STAT: s_axi_rdata <= {27'h0, readyBusy1_n,
                        readyBusy0_n, errEv_r, initDone_r,
                        state_r == S_IDLE};
                    `NHBA_REG_IRQ: s_axi_rdata <= {29'h0, irqStat};
                    `NHBA_REG_MASK: s_axi_rdata <= {29'h0, irqMask};
                    `NHBA_REG_RDATA: s_axi_rdata <= {24'h0, rdByte_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Host configuration registers.
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            writeGuard_n <= 1'b0;
            lockStrap <= 1'b0;
            target_r <= 1'b0;
            columnAddr <= 13'h0000;
            page_addr_r <= 6'h00;
            blockAddr_r <= 17'h00000;
            cmdByte_r <= 8'h00;
            kind_r <= `NHBA_KIND_CMD;
        end
        else if (wrFire && state_r == S_IDLE)
        begin
            case (wIdx)
                `NHBA_REG_CTRL:
                begin
                    writeGuard_n <= ~wData_r[`NHBA_CTRL_WP];
                    target_r <= wData_r[`NHBA_CTRL_CE];
                    lockStrap <= wData_r[`NHBA_CTRL_LOCK];
                end
                `NHBA_REG_ADDRLO:
                begin
                    columnAddr <= wData_r[12:0];
                    page_addr_r <= wData_r[18:13];
                end
                `NHBA_REG_ADDRHI: blockAddr_r <= wData_r[16:0];
                `NHBA_REG_DATA:
                begin
                    cmdByte_r <= wData_r[7:0];
                    kind_r <= wData_r[9:8];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer.
    // ------------------------------------------------------------
    nhba_addr_pack uPack
    (
        .columnAddr(columnAddr),
        .pageAddr(page_addr_r),
        .blockAddr(blockAddr_r),
        .byteIdx(addrIdx_r),
        .addrByte(packByte),
        .addrBad(addrBad)
    );

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            addrIdx_r <= 3'h0;
            byte_r <= 8'h00;
            rdByte_r <= 8'h00;
            initDone_r <= 1'b0;
            errEv_r <= 1'b0;
            doneEv_r <= 1'b0;
            ioOut <= 8'h00;
            ioOe <= 1'b0;
            chipSel0_n <= 1'b1;
            chipSel1_n <= 1'b1;
            cmdLatch <= 1'b0;
            addrLatch <= 1'b0;
            writeStrobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
        end
        else
        begin
            doneEv_r <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (goReq)
                    begin
                        if (!cmdOk || (kind_r == `NHBA_KIND_ADDR &&
                            addrBad))
                        begin
                            errEv_r <= 1'b1;
                            doneEv_r <= 1'b1;
                        end
                        else
                        begin
                            errEv_r <= 1'b0;
                            addrIdx_r <= 3'h0;
                            state_r <= S_SETUP;
                        end
                    end
                end
                S_SETUP:
                begin
                    chipSel0_n <= target_r;
                    chipSel1_n <= ~target_r;
                    cmdLatch <= kind_r == `NHBA_KIND_CMD;
                    addrLatch <= kind_r == `NHBA_KIND_ADDR;
                    ioOe <= kind_r != `NHBA_KIND_RDATA;
                    ioOut <= kind_r == `NHBA_KIND_ADDR ? packByte :
                        cmdByte_r;
                    writeStrobe_n <= kind_r == `NHBA_KIND_RDATA;
                    read_strobe_n <= kind_r != `NHBA_KIND_RDATA;
                    cnt_r <= `NHBA_STROBE_CYC;
                    state_r <= S_PULSE;
                end
                S_PULSE:
                begin
                    if (cnt_r != 4'h0)
                        cnt_r <= cnt_r - 4'h1;
                    else
                    begin
                        writeStrobe_n <= 1'b1;
                        read_strobe_n <= 1'b1;
                        if (kind_r == `NHBA_KIND_RDATA)
                            rdByte_r <= ioIn;
                        cnt_r <= `NHBA_STROBE_CYC;
                        state_r <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    if (cnt_r != 4'h0)
                        cnt_r <= cnt_r - 4'h1;
                    else if (kind_r == `NHBA_KIND_ADDR &&
                        addrIdx_r != 3'h4)
                    begin
                        addrIdx_r <= addrIdx_r + 3'h1;
                        state_r <= S_SETUP;
                    end
                    else
                        state_r <= S_DONE;
                end
                S_DONE:
                begin
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b0;
                    chipSel0_n <= 1'b1;
                    chipSel1_n <= 1'b1;
                    if (kind_r == `NHBA_KIND_CMD &&
                        cmdByte_r == `NHBA_CMD_RESET)
                        initDone_r <= 1'b1;
                    doneEv_r <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (sys_rst)
            rdyPrev_r <= 1'b1;
        else
            rdyPrev_r <= selReady;
    end

    nhba_irq #(.N(3)) uIrq
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .events({errEv_r & doneEv_r, selReady & ~rdyPrev_r, doneEv_r}),
        .readClr(s_axi_arvalid && s_axi_arready &&
            rIdx == `NHBA_REG_IRQ),
        .maskIn(wData_r[2:0]),
        .maskWr(wrFire && wIdx == `NHBA_REG_MASK),
        .status(irqStat),
        .mask(irqMask),
        .irq(irq)
    );
endmodule

// >>> rtl/nhba_irq.v
`timescale 1ns/1ps
`include "nhba_map.vh"
// ----------------------------------------------------------------
// Sticky event bits with mask and read clear.
// ----------------------------------------------------------------
module nhba_irq
#(
    parameter N = 3
)
(
    clock,
    sys_rst,
    events,
    readClr,
    maskIn,
    maskWr,
    status,
    mask,
    irq
);
    input wire clock;
    input wire sys_rst;
    input wire [N-1:0] events;
    input wire readClr;
    input wire [N-1:0] maskIn;
    input wire maskWr;
    output reg [N-1:0] status;
    output reg [N-1:0] mask;
    output wire irq;

    assign irq = |(status & mask);

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            status <= {N{1'b0}};
            mask <= {N{1'b0}};
        end
        else
        begin
            status <= (readClr ? {N{1'b0}} : status) | events;
            if (maskWr)
                mask <= maskIn;
        end
    end
endmodule

// >>> rtl/nhba_map.vh
`ifndef NHBA_MAP_VH
`define NHBA_MAP_VH
`define NHBA_REG_CTRL 4'h0
`define NHBA_REG_ADDRLO 4'h1
`define NHBA_REG_ADDRHI 4'h2
`define NHBA_REG_DATA 4'h3
`define NHBA_REG_STAT 4'h4
`define NHBA_REG_IRQ 4'h5
`define NHBA_REG_MASK 4'h6
`define NHBA_REG_RDATA 4'h7
`define NHBA_CMD_RESET 8'hFF
`define NHBA_CMD_STATUS 8'h70
`define NHBA_CMD_STATUS_ENH 8'h78
`define NHBA_PAGE_BYTES 13'h1100
`define NHBA_MAIN_BYTES 13'h1000
`define NHBA_SPARE_BYTES 13'h0100
`define NHBA_BLOCK_PAGES 7'h40
`define NHBA_CA12_BIT 12
`define NHBA_CTRL_GO 0
`define NHBA_CTRL_WP 1
`define NHBA_CTRL_CE 2
`define NHBA_CTRL_LOCK 3
`define NHBA_KIND_CMD 2'h0
`define NHBA_KIND_ADDR 2'h1
`define NHBA_KIND_WDATA 2'h2
`define NHBA_KIND_RDATA 2'h3
`define NHBA_ST_READY 0
`define NHBA_ST_INIT 1
`define NHBA_ST_ERR 2
`define NHBA_IRQ_DONE 0
`define NHBA_IRQ_RDY 1
`define NHBA_IRQ_ERR 2
`define NHBA_STROBE_CYC 4'h2
`endif

// >>> tb/nhba_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Device pin protocol checks.
// ----------------------------------------------------------
module nhba_asserts
(
    input wire clock,
    input wire sys_rst,
    input wire [7:0] ioOut,
    input wire ioOe,
    input wire chipSel0_n,
    input wire chipSel1_n,
    input wire cmdLatch,
    input wire addrLatch,
    input wire writeStrobe_n,
    input wire read_strobe_n,
    input wire readyBusy0_n,
    input wire readyBusy1_n
);
    logic wsQ_r;
    logic seen_r;
    logic [2:0] nAdr_r;
    wire rise = writeStrobe_n && !wsQ_r;
    wire ceOn = !chipSel0_n || !chipSel1_n;
    wire busy = (!chipSel0_n && !readyBusy0_n) ||
        (!chipSel1_n && !readyBusy1_n);
    always @(posedge clock)
    begin
        wsQ_r <= writeStrobe_n;
        seen_r <= !sys_rst &&
            (seen_r || (rise && cmdLatch && ioOut == 8'hFF));
        nAdr_r <= (sys_rst || !ceOn) ? 3'h0 :
            nAdr_r + {2'h0, rise && addrLatch};
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sequence s_wrPulse;
        !writeStrobe_n [*3] ##1 writeStrobe_n;
    endsequence
    sequence s_qual;
        read_strobe_n && ceOn && !(cmdLatch && addrLatch);
    endsequence
    a_cmd_qual: assert property (rise && cmdLatch |-> s_qual)
        else $error("command latched with bad qualifiers");
    a_addr_qual: assert property (rise && addrLatch |-> s_qual)
        else $error("address latched with bad qualifiers");
    a_wr_pulse: assert property ($fell(writeStrobe_n) |-> s_wrPulse)
        else $error("write strobe pulse width wrong");
    a_wr_hold: assert property (!writeStrobe_n |=> ioOe && $stable(ioOut))
        else $error("bus not held through write strobe");
    a_rd_bus: assert property (!read_strobe_n |-> !ioOe && writeStrobe_n
        && !cmdLatch && !addrLatch)
        else $error("read strobe with bad qualifiers");
    a_col_high: assert property (rise && addrLatch && nAdr_r == 3'h1 |->
        ioOut[7:5] == 3'h0 && (!ioOut[4] || ioOut[3:0] == 4'h0))
        else $error("second address byte malformed");
    a_blk_top: assert property (rise && addrLatch && nAdr_r == 3'h4 |->
        ioOut[7:1] == 7'h00)
        else $error("fifth address byte malformed");
    a_first_reset: assert property (rise && cmdLatch && !seen_r |->
        ioOut == 8'hFF)
        else $error("first command is not reset");
    a_one_ce: assert property (chipSel0_n || chipSel1_n)
        else $error("both targets selected");
    a_busy_cmd: assert property ($fell(writeStrobe_n) && cmdLatch && busy |->
        ioOut == 8'h70 || ioOut == 8'h78)
        else $error("command sent to busy target");
endmodule

bind nhba_host nhba_asserts nhba_asserts_inst
(
    .clock(clock), .sys_rst(sys_rst), .ioOut(ioOut), .ioOe(ioOe),
    .chipSel0_n(chipSel0_n), .chipSel1_n(chipSel1_n),
    .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .readyBusy0_n(readyBusy0_n), .readyBusy1_n(readyBusy1_n)
);

// >>> tb/nhba_dev.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Behavioural target with one die.
// ----------------------------------------------------------
module nhba_dev
(
    input wire clock,
    input wire cs_n,
    input wire cl,
    input wire al,
    input wire ws_n,
    input wire rs_n,
    input wire wg_n,
    input wire lk,
    input wire [7:0] io,
    output logic [7:0] q,
    output logic oe,
    output wire pull
);
    logic [7:0] cmd = 8'h00;
    logic [39:0] adr = 40'h0;
    logic [7:0] din = 8'h00;
    logic lock = 1'b0;
    logic rstd = 1'b0;
    logic ecc = 1'b0;
    int na = 0;
    int nc = 0;
    int idx = 0;
    int cyc = 0;
    int bEnd = 0;
    wire stat = cmd == 8'h70 || cmd == 8'h78;
    wire sel = !cs_n && rs_n;
    assign pull = cyc < bEnd;
    initial oe = 1'b0;
    always @(posedge clock)
        cyc <= cyc + 1;
    always @(posedge ws_n)
    begin
        if (sel && cl && !al && (rstd || io == 8'hFF) &&
            (!pull || io == 8'h70 || io == 8'h78))
        begin
            cmd = io;
            nc = nc + 1;
            na = 0;
            idx = 0;
            rstd = 1'b1;
            if (io == 8'hFF)
                lock = lk;
            if (io == 8'h30 || (wg_n && (io == 8'h10 || io == 8'hD0)))
                bEnd = cyc + 400;
        end
        if (sel && al && !cl && rstd && !pull && na < 5)
        begin
            adr = {adr[31:0], io};
            na = na + 1;
        end
        if (sel && !al && !cl && !pull)
            din = io;
    end
    always @(negedge rs_n) #1
        if (!cs_n && !cl && !al && ws_n && (stat || !pull))
        begin
            oe = 1'b1;
            q = stat ? {wg_n, !pull, 6'h00} : 8'h3C + idx[7:0];
            idx = (idx + 1) % 4352;
        end
    always @(posedge rs_n or posedge cs_n)
        oe = 1'b0;
endmodule

// >>> tb/nhba_host_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Register-level tests against two targets.
// ----------------------------------------------------------
module nhba_host_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] awA = 5'h00;
    logic [4:0] arA = 5'h00;
    logic [31:0] wD = 32'h0;
    logic awV = 1'b0;
    logic wV = 1'b0;
    logic bR = 1'b0;
    logic arV = 1'b0;
    logic rR = 1'b0;
    logic [31:0] v;
    int err_count = 0;
    int n_checks = 0;
    wire awRdy, wRdy, bV, arRdy, rV, ioOe, cs0, cs1, cl, al, ws, rs, wg;
    wire lk, oe0, oe1, p0, p1, irq;
    wire [1:0] bRsp, rRsp;
    wire [31:0] rD;
    wire [7:0] ioOut, q0, q1;
    wire [7:0] ioIn = ioOe ? ioOut : oe0 ? q0 : oe1 ? q1 : {8{clock}} ^ 8'h5A;
    wire rb0 = p0 ? 1'b0 : 1'b1;
    wire rb1 = p1 ? 1'b0 : 1'b1;
    always #2 clock = ~clock;
    nhba_host nhba_host_inst
    (
        .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
        .s_axi_bresp(bRsp), .s_axi_bvalid(bV), .s_axi_bready(bR),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
        .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV),
        .s_axi_rready(rR), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .chipSel0_n(cs0), .chipSel1_n(cs1), .cmdLatch(cl), .addrLatch(al),
        .writeStrobe_n(ws), .read_strobe_n(rs), .writeGuard_n(wg),
        .lockStrap(lk), .readyBusy0_n(rb0), .readyBusy1_n(rb1), .irq(irq)
    );
    nhba_dev nhba_dev_inst
    (
        .clock(clock), .cs_n(cs0), .cl(cl), .al(al), .ws_n(ws), .rs_n(rs),
        .wg_n(wg), .lk(lk), .io(ioIn), .q(q0), .oe(oe0), .pull(p0)
    );
    nhba_dev nhba_dev_inst1
    (
        .clock(clock), .cs_n(cs1), .cl(cl), .al(al), .ws_n(ws), .rs_n(rs),
        .wg_n(wg), .lk(lk), .io(ioIn), .q(q1), .oe(oe1), .pull(p1)
    );
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic pa, pw, pb, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge clock);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        bR <= 1'b1;
        while (pb)
        begin
            @(negedge clock);
            ta = pa && awRdy;
            tw = pw && wRdy;
            pb = !bV;
            if (!pb) chk(bRsp, 40'h0);
            @(posedge clock);
            if (ta) awV <= 1'b0;
            if (tw) wV <= 1'b0;
            if (!pb) bR <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        logic pa, pr, ta;
        pa = 1'b1;
        pr = 1'b1;
        @(posedge clock);
        arA <= a;
        arV <= 1'b1;
        rR <= 1'b1;
        while (pr)
        begin
            @(negedge clock);
            ta = pa && arRdy;
            pr = !rV;
            d = rD;
            if (!pr) chk(rRsp, 40'h0);
            @(posedge clock);
            if (ta) arV <= 1'b0;
            if (!pr) rR <= 1'b0;
            pa = pa && !ta;
        end
    endtask
    task automatic go(input logic [9:0] dk, input logic [3:0] ct);
        logic [31:0] s;
        s = 32'h0;
        wr(5'h0C, {22'h0, dk});
        wr(5'h00, {28'h0, ct} | 32'h1);
        repeat (100) if (s[0] !== 1'b1) rd(5'h10, s);
        @(negedge clock);
    endtask
    task automatic ended(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        chk({cs0, cs1, cl, al, ws, rs, ioOe, irq, wg}, 40'h198);
        sys_rst <= 1'b0;
        rd(5'h10, v);
        chk(v, 40'h19);
        wr(5'h18, 32'h7);
        go(10'h070, 4'h0);
        chk(nhba_dev_inst.nc, 40'h0);
        rd(5'h10, v);
        chk(v[2:0], 40'h5);
        chk(irq, 40'h1);
        rd(5'h14, v);
        chk(v, 40'h5);
        @(negedge clock);
        chk(irq, 40'h0);
        go(10'h0FF, 4'h8);
        chk({nhba_dev_inst.cmd, nhba_dev_inst.lock, wg}, 40'h3FF);
        ended("order");
        wr(5'h04, 32'h1100);
        go(10'h100, 4'h8);
        chk(nhba_dev_inst.na, 40'h0);
        wr(5'h04, 32'h5705A);
        wr(5'h08, 32'h5C3);
        go(10'h100, 4'h8);
        chk(nhba_dev_inst.adr, 40'h5A10EB7001);
        chk(nhba_dev_inst.na, 40'h5);
        go(10'h2C3, 4'h8);
        chk(nhba_dev_inst.din, 40'hC3);
        for (int i = 0; i < 2; i++)
        begin
            go(10'h300, 4'h8);
            rd(5'h1C, v);
            chk(v, 40'h3C + i);
        end
        ended("address");
        rd(5'h14, v);
        go(10'h030, 4'h8);
        chk(rb0, 40'h0);
        go(10'h000, 4'h8);
        go(10'h070, 4'h8);
        chk(nhba_dev_inst.cmd, 40'h70);
        go(10'h300, 4'h8);
        rd(5'h1C, v);
        chk(v, 40'h80);
        v = 32'h0;
        repeat (300) if (v[3] !== 1'b1) rd(5'h10, v);
        rd(5'h14, v);
        chk(v, 40'h7);
        ended("busy");
        wr(5'h18, 32'h0);
        go(10'h070, 4'h8);
        chk(irq, 40'h0);
        rd(5'h14, v);
        chk(v, 40'h1);
        go(10'h010, 4'hA);
        chk({wg, rb0}, 40'h1);
        go(10'h0FF, 4'hC);
        chk(nhba_dev_inst1.cmd, 40'hFF);
        chk(nhba_dev_inst.cmd, 40'h10);
        go(10'h030, 4'h8);
        go(10'h000, 4'hC);
        chk(nhba_dev_inst1.cmd, 40'h0);
        ended("target");
        finish_test();
    end
    initial
    begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule
